// File: rtl/ccp_pkg.sv
package ccp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS1 = 8'h0C;
  localparam logic [7:0] IDX_FLAGS2 = 8'h0D;
  localparam logic [7:0] IDX_VAL1L = 8'h15;
  localparam logic [7:0] IDX_VAL1H = 8'h16;
  localparam logic [7:0] IDX_CTRL1 = 8'h17;
  localparam logic [7:0] IDX_VAL2L = 8'h1B;
  localparam logic [7:0] IDX_VAL2H = 8'h1C;
  localparam logic [7:0] IDX_CTRL2 = 8'h1D;
  localparam logic [7:0] IDX_ENABLES1 = 8'h8C;
  localparam logic [7:0] IDX_ENABLES2 = 8'h8D;

  localparam int ADDR_W = 12;
  localparam int CTRL_W = 6;
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB = 4;

  // Event flag positions
  localparam int FLAG1_UNIT1_BIT = 2;
  localparam int FLAG1_TIMER1_COUNT_OVF_BIT = 0;
  localparam int FLAG2_UNIT2_BIT = 0;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  localparam logic [1:0] GROUP_CAP = 2'h1;
  localparam logic [1:0] GROUP_CMP = 2'h2;
  localparam logic [1:0] GROUP_PWM = 2'h3;

  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hF;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] value;
    logic [3:0] presc;
    logic sync1;
    logic sync2;
    logic prev;
    logic out;
    logic oe_n;
    logic eq_prev;
  } unit_state_t;

  typedef struct packed {
    unit_state_t [1:0] unit;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] enables1;
    logic [7:0] enables2;
    logic timer1_reset;
    logic adc_start;
    logic reset_from_unit2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

// File: rtl/capture_compare_unit.sv
`timescale 1ns/1ps

// Function
// - Mode 0000 turns unit off, clears latch, prescaler and compare history
// - Modes 0100-0111 pick capture edge and prescale
// - Modes 1000/1001 set/clear pin, raise flag
// - Mode 1010 raises flag only
// - Mode 1011 flag plus special event trigger
// - Modes 11xx give no PWM output, bits 5-4 duty low only stored
// - Value low/high and control are read/write
// - Control bits 7-6 read zero
// - Capture copies full timer1 count
// - Capture sets flag; only software clears
// - New capture overwrites unread value
// - Capture watches pin level, even driven
// - Mode change may set flag spuriously
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps count; software clears first
// - Compare equality applies action and flag together
// - Units identical except trigger side effects
// - No timer2 base; PWM modes only hold the compare latch on the pin
// - Software timer1 write beats trigger reset
// - Zero control forces compare latch low
// - Unit 2 trigger never sets overflow flag
module capture_compare_unit #(
  parameter int TIMER_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TIMER_W-1:0] timer1_count,
  input wire logic timer1_write,
  input wire logic timer1_overflow,
  input wire logic adc_enabled,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] unit_pin_in,
  output logic [1:0] unit_pin_out,
  output logic [1:0] unit_pin_oe_n,
  output logic timer1_reset,
  output logic adc_start
);

  if (TIMER_W != 16) begin : g_width_check
    $error("TIMER_W must be 16");
  end

  ccp_pkg::state_t s_r;
  ccp_pkg::state_t s_nxt;
  logic [1:0] cap_w;
  logic [1:0] hit_w;
  logic [1:0] trig_w;
  logic acc_done_w;
  logic [7:0] idx_w;

  assign acc_done_w = psel & penable & s_r.pready;
  assign idx_w = paddr[9:2];

  always_comb begin
    logic [3:0] mode;
    logic [1:0] grp;
    logic rise;
    logic fall;
    logic match;
    logic wr;
    logic mapped;
    logic [7:0] rd;
    mode = 4'h0;
    grp = 2'h0;
    rise = 1'b0;
    fall = 1'b0;
    match = 1'b0;
    rd = 8'h00;
    mapped = 1'b1;
    s_nxt = s_r;
    cap_w = 2'b00;
    hit_w = 2'b00;
    trig_w = 2'b00;
    wr = acc_done_w & pwrite & (paddr[1:0] == 2'b00) &
      (paddr[ccp_pkg::ADDR_W-1:10] == 2'b00);

    // Software writes land first so that hardware events win below
    if (wr) begin
      case (idx_w)
        ccp_pkg::IDX_FLAGS1: s_nxt.flags1 = pwdata[7:0];
        ccp_pkg::IDX_FLAGS2: s_nxt.flags2 = pwdata[7:0];
        ccp_pkg::IDX_ENABLES1: s_nxt.enables1 = pwdata[7:0];
        ccp_pkg::IDX_ENABLES2: s_nxt.enables2 = pwdata[7:0];
        ccp_pkg::IDX_VAL1L: s_nxt.unit[0].value[7:0] = pwdata[7:0];
        ccp_pkg::IDX_VAL1H: s_nxt.unit[0].value[15:8] = pwdata[7:0];
        ccp_pkg::IDX_CTRL1: s_nxt.unit[0].ctrl = pwdata[5:0];
        ccp_pkg::IDX_VAL2L: s_nxt.unit[1].value[7:0] = pwdata[7:0];
        ccp_pkg::IDX_VAL2H: s_nxt.unit[1].value[15:8] = pwdata[7:0];
        ccp_pkg::IDX_CTRL2: s_nxt.unit[1].ctrl = pwdata[5:0];
        default: begin
        end
      endcase
    end

    for (int u = 0; u < 2; u++) begin
      mode = s_r.unit[u].ctrl[3:0];
      grp = mode[3:2];
      // Level of the pin itself, whatever drives it
      s_nxt.unit[u].sync1 = unit_pin_in[u];
      s_nxt.unit[u].sync2 = s_r.unit[u].sync1;
      s_nxt.unit[u].prev = s_r.unit[u].sync2;
      rise = s_r.unit[u].sync2 & ~s_r.unit[u].prev;
      fall = ~s_r.unit[u].sync2 & s_r.unit[u].prev;
      s_nxt.unit[u].oe_n = port_c_direction[u];

      // Prescaler kept across capture-mode changes, cleared otherwise
      if (grp != ccp_pkg::GROUP_CAP) begin
        s_nxt.unit[u].presc = 4'h0;
      end
      case (mode)
        ccp_pkg::MODE_CAP_FALL: cap_w[u] = fall;
        ccp_pkg::MODE_CAP_RISE: cap_w[u] = rise;
        ccp_pkg::MODE_CAP_RISE4: begin
          if (rise) begin
            cap_w[u] = (s_r.unit[u].presc == ccp_pkg::PRESC_LAST4);
            s_nxt.unit[u].presc = cap_w[u] ? 4'h0 : s_r.unit[u].presc + 4'h1;
          end
        end
        ccp_pkg::MODE_CAP_RISE16: begin
          if (rise) begin
            cap_w[u] = (s_r.unit[u].presc == ccp_pkg::PRESC_LAST16);
            s_nxt.unit[u].presc = s_r.unit[u].presc + 4'h1;
          end
        end
        default: begin
        end
      endcase
      if (cap_w[u]) begin
        s_nxt.unit[u].value = timer1_count;
      end

      // Edge of equality, not its level
      match = (s_r.unit[u].value == timer1_count);
      hit_w[u] = (grp == ccp_pkg::GROUP_CMP) & match & ~s_r.unit[u].eq_prev;
      s_nxt.unit[u].eq_prev = (grp == ccp_pkg::GROUP_CMP) & match;
      if (hit_w[u]) begin
        case (mode)
          ccp_pkg::MODE_CMP_SET: s_nxt.unit[u].out = 1'b1;
          ccp_pkg::MODE_CMP_CLR: s_nxt.unit[u].out = 1'b0;
          ccp_pkg::MODE_CMP_SOFT: s_nxt.unit[u].out = s_r.unit[u].out;
          ccp_pkg::MODE_CMP_TRIG: trig_w[u] = 1'b1;
          default: begin
          end
        endcase
      end

      // Off clears latch, prescaler and compare history
      if (mode == ccp_pkg::MODE_OFF) begin
        s_nxt.unit[u].out = 1'b0;
        s_nxt.unit[u].presc = 4'h0;
        s_nxt.unit[u].eq_prev = 1'b0;
      end
      // PWM waveform is not generated here; duty bits only stored
      // No timer2 inside and no timer2 input, so neither unit has a PWM time base
    end

    // A mode write can raise a flag, e.g. entering compare while value equals timer1
    // Flags: hardware set wins over a same-cycle software clear
    if (cap_w[0] | hit_w[0]) begin
      s_nxt.flags1[ccp_pkg::FLAG1_UNIT1_BIT] = 1'b1;
    end
    if (cap_w[1] | hit_w[1]) begin
      s_nxt.flags2[ccp_pkg::FLAG2_UNIT2_BIT] = 1'b1;
    end

    // Software write to timer1 takes precedence over the trigger
    s_nxt.timer1_reset = (trig_w[0] | trig_w[1]) & ~timer1_write;
    s_nxt.adc_start = trig_w[1] & adc_enabled;
    // Timer wraps one cycle after our reset pulse; mask that overflow only while unit 2 is in mode 1011
    s_nxt.reset_from_unit2 = s_r.timer1_reset &
      (s_r.unit[1].ctrl[3:0] == ccp_pkg::MODE_CMP_TRIG);
    if (timer1_overflow & ~s_r.reset_from_unit2) begin
      s_nxt.flags1[ccp_pkg::FLAG1_TIMER1_COUNT_OVF_BIT] = 1'b1;
    end

    // Two-cycle access phase keeps pready registered
    case (idx_w)
      ccp_pkg::IDX_FLAGS1: rd = s_r.flags1;
      ccp_pkg::IDX_FLAGS2: rd = s_r.flags2;
      ccp_pkg::IDX_ENABLES1: rd = s_r.enables1;
      ccp_pkg::IDX_ENABLES2: rd = s_r.enables2;
      ccp_pkg::IDX_VAL1L: rd = s_r.unit[0].value[7:0];
      ccp_pkg::IDX_VAL1H: rd = s_r.unit[0].value[15:8];
      ccp_pkg::IDX_CTRL1: rd = {2'b00, s_r.unit[0].ctrl};
      ccp_pkg::IDX_VAL2L: rd = s_r.unit[1].value[7:0];
      ccp_pkg::IDX_VAL2H: rd = s_r.unit[1].value[15:8];
      ccp_pkg::IDX_CTRL2: rd = {2'b00, s_r.unit[1].ctrl};
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[ccp_pkg::ADDR_W-1:10] != 2'b00) begin
      mapped = 1'b0;
    end
    s_nxt.pready = psel & penable & ~s_r.pready;
    if (psel & penable & ~s_r.pready) begin
      s_nxt.prdata = (mapped & ~pwrite) ? {24'h000000, rd} : 32'h00000000;
      s_nxt.pslverr = ~mapped;
    end else begin
      s_nxt.prdata = 32'h00000000;
      s_nxt.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int u = 0; u < 2; u++) begin
        s_r.unit[u].ctrl <= ccp_pkg::CTRL_RESET;
        s_r.unit[u].value <= ccp_pkg::VALUE_RESET;
        s_r.unit[u].presc <= 4'h0;
        s_r.unit[u].sync1 <= 1'b0;
        s_r.unit[u].sync2 <= 1'b0;
        s_r.unit[u].prev <= 1'b0;
        s_r.unit[u].out <= 1'b0;
        s_r.unit[u].oe_n <= 1'b1;
        s_r.unit[u].eq_prev <= 1'b0;
      end
      s_r.flags1 <= ccp_pkg::FLAGS_RESET;
      s_r.flags2 <= ccp_pkg::FLAGS_RESET;
      s_r.enables1 <= ccp_pkg::ENABLES_RESET;
      s_r.enables2 <= ccp_pkg::ENABLES_RESET;
      s_r.timer1_reset <= 1'b0;
      s_r.adc_start <= 1'b0;
      s_r.reset_from_unit2 <= 1'b0;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h00000000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign unit_pin_out = {s_r.unit[1].out, s_r.unit[0].out};
  assign unit_pin_oe_n = {s_r.unit[1].oe_n, s_r.unit[0].oe_n};
  assign timer1_reset = s_r.timer1_reset;
  assign adc_start = s_r.adc_start;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cap0;
    cap_w[0] && !(acc_done_w && pwrite && idx_w == ccp_pkg::IDX_FLAGS1);
  endsequence

  property p_off_clears;
    s_r.unit[0].ctrl[3:0] == ccp_pkg::MODE_OFF |=> !s_r.unit[0].out && s_r.unit[0].presc == 4'h0;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("Off mode left state");

  property p_cap_value;
    cap_w[0] |=> s_r.unit[0].value == $past(timer1_count);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("Capture value wrong");

  property p_cap_flag;
    s_cap0 or (cap_w[0] ##0 1'b1) |=> s_r.flags1[ccp_pkg::FLAG1_UNIT1_BIT];
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("Capture flag not set");

  property p_set_pin;
    hit_w[0] && s_r.unit[0].ctrl[3:0] == ccp_pkg::MODE_CMP_SET |=> s_r.unit[0].out
      && s_r.flags1[ccp_pkg::FLAG1_UNIT1_BIT];
  endproperty
  a_set_pin: assert property (p_set_pin) else $error("Set on match failed");

  property p_soft_only;
    hit_w[0] && s_r.unit[0].ctrl[3:0] == ccp_pkg::MODE_CMP_SOFT |=> $stable(s_r.unit[0].out);
  endproperty
  a_soft_only: assert property (p_soft_only) else $error("Pin moved in soft mode");

  property p_trig_reset;
    trig_w[0] && !timer1_write |=> timer1_reset;
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("Trigger reset missing");

  property p_write_wins;
    timer1_write |=> !timer1_reset;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("Trigger beat timer1 write");

  property p_ctrl_top_zero;
    acc_done_w && !pwrite && paddr == {2'b00, ccp_pkg::IDX_CTRL1, 2'b00} |-> prdata[7:6] == 2'b00;
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("Control top bits set");

  property p_hit_once;
    hit_w[0] |=> !hit_w[0];
  endproperty
  a_hit_once: assert property (p_hit_once) else $error("Compare fired twice");

  property p_cap_once;
    cap_w[0] |=> !cap_w[0] ##1 !cap_w[0];
  endproperty
  a_cap_once: assert property (p_cap_once) else $error("Double capture");

  property p_presc_clear;
    s_r.unit[1].ctrl[3:2] != ccp_pkg::GROUP_CAP |=> s_r.unit[1].presc == 4'h0;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("Prescaler not cleared");

  property p_clr_pin;
    hit_w[0] && s_r.unit[0].ctrl[3:0] == ccp_pkg::MODE_CMP_CLR |=> !s_r.unit[0].out
      && s_r.flags1[ccp_pkg::FLAG1_UNIT1_BIT];
  endproperty
  a_clr_pin: assert property (p_clr_pin) else $error("Clear on match failed");

  property p_set_pin2;
    hit_w[1] && s_r.unit[1].ctrl[3:0] == ccp_pkg::MODE_CMP_SET |=> s_r.unit[1].out
      && s_r.flags2[ccp_pkg::FLAG2_UNIT2_BIT];
  endproperty
  a_set_pin2: assert property (p_set_pin2) else $error("Unit 2 set on match failed");

  property p_trig_adc;
    trig_w[1] && adc_enabled |=> adc_start;
  endproperty
  a_trig_adc: assert property (p_trig_adc) else $error("Conversion start missing");

  property p_adc_unit2_only;
    trig_w[0] && !trig_w[1] |=> !adc_start;
  endproperty
  a_adc_unit2_only: assert property (p_adc_unit2_only) else $error("Unit 1 started conversion");

  property p_ovf_masked;
    timer1_overflow && s_r.reset_from_unit2 && !(acc_done_w && pwrite)
      && !s_r.flags1[ccp_pkg::FLAG1_TIMER1_COUNT_OVF_BIT] |=> !s_r.flags1[ccp_pkg::FLAG1_TIMER1_COUNT_OVF_BIT];
  endproperty
  a_ovf_masked: assert property (p_ovf_masked) else $error("Overflow not masked");

  property p_ovf_flag;
    timer1_overflow && !s_r.reset_from_unit2 |=> s_r.flags1[ccp_pkg::FLAG1_TIMER1_COUNT_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow flag not set");

  property p_cap_value2;
    cap_w[1] |=> s_r.unit[1].value == $past(timer1_count);
  endproperty
  a_cap_value2: assert property (p_cap_value2) else $error("Unit 2 capture value wrong");

  property p_cap_flag2;
    cap_w[1] |=> s_r.flags2[ccp_pkg::FLAG2_UNIT2_BIT];
  endproperty
  a_cap_flag2: assert property (p_cap_flag2) else $error("Unit 2 capture flag not set");

  property p_flag_sticky;
    s_r.flags1[ccp_pkg::FLAG1_UNIT1_BIT] && !(acc_done_w && pwrite && idx_w ==
      ccp_pkg::IDX_FLAGS1) |=> s_r.flags1[ccp_pkg::FLAG1_UNIT1_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Flag cleared by hardware");

  property p_fall_only;
    s_r.unit[0].ctrl[3:0] == ccp_pkg::MODE_CAP_FALL && s_r.unit[0].sync2
      && !s_r.unit[0].prev |-> !cap_w[0];
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("Rise captured in fall mode");

  property p_zero_ctrl_pin;
    acc_done_w && pwrite && paddr == {2'b00, ccp_pkg::IDX_CTRL1, 2'b00}
      && pwdata[5:0] == 6'h00 |=> ##1 !s_r.unit[0].out;
  endproperty
  a_zero_ctrl_pin: assert property (p_zero_ctrl_pin) else $error("Latch not forced low");

  property p_unmapped_err;
    acc_done_w && paddr == 12'h100 |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped access accepted");

  property p_ctrl2_top_zero;
    acc_done_w && !pwrite && paddr == {2'b00, ccp_pkg::IDX_CTRL2, 2'b00} |-> prdata[7:6] == 2'b00;
  endproperty
  a_ctrl2_top_zero: assert property (p_ctrl2_top_zero) else $error("Control 2 top bits set");

endmodule

// File: tb/pin_source.sv
`timescale 1ns/1ps
module pin_source (
  input wire logic pclk,
  input wire logic [1:0] level,
  input wire logic [1:0] drv,
  input wire logic [1:0] oe_n,
  output logic [1:0] pin
);
  logic [1:0] ext_r;
  // Source moves just after an edge, never mid-cycle
  always_ff @(posedge pclk) begin
    ext_r <= level;
  end
  // Source backs off where the unit drives, so the wire shows the latch
  assign pin = (drv & ~oe_n) | (ext_r & oe_n);
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] CTL_I [2] = '{ccp_pkg::IDX_CTRL1, ccp_pkg::IDX_CTRL2};
  localparam logic [7:0] VL_I [2] = '{ccp_pkg::IDX_VAL1L, ccp_pkg::IDX_VAL2L};
  localparam logic [7:0] VH_I [2] = '{ccp_pkg::IDX_VAL1H, ccp_pkg::IDX_VAL2H};
  localparam logic [7:0] FL_I [2] = '{ccp_pkg::IDX_FLAGS1, ccp_pkg::IDX_FLAGS2};
  localparam logic [7:0] RST_I [4] = '{FL_I[0], FL_I[1], CTL_I[0], CTL_I[1]};
  localparam logic [7:0] RW_I [6] = '{VL_I[0], VH_I[0], VL_I[1], VH_I[1],
    ccp_pkg::IDX_ENABLES1, ccp_pkg::IDX_ENABLES2};
  localparam logic [3:0] CMP_M [5] = '{4'h9, 4'hB, 4'hB, 4'h8, 4'hA};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] t1;
  logic t1_wr, t1_ovf, adc_en, t1_rst, adc_go;
  logic [1:0] dir, lvl, pin, pout, poe_n, pexp;
  int err_total, n_compared, trig_n, adc_n;

  capture_compare_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer1_count(t1),
    .timer1_write(t1_wr), .timer1_overflow(t1_ovf), .adc_enabled(adc_en),
    .port_c_direction(dir), .unit_pin_in(pin), .unit_pin_out(pout),
    .unit_pin_oe_n(poe_n), .timer1_reset(t1_rst), .adc_start(adc_go));
  pin_source far_u (.pclk(pclk), .level(lvl), .drv(pout), .oe_n(poe_n), .pin(pin));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // Timer wraps on the special reset, so its overflow follows one cycle later
  always @(posedge pclk) begin
    if (t1_rst === 1'h1) trig_n++;
    if (adc_go === 1'h1) adc_n++;
    t1_ovf <= t1_rst;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [15:0] cap_exp(input logic [3:0] m, input logic [15:0] v, input int n);
    return (m == ccp_pkg::MODE_CAP_FALL) ? v + 16'h0001 : v + 16'(2 * n - 2);
  endfunction

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 40) begin
      chk(16'h0000, 16'h0001);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
  endtask

  task automatic flag_chk(input int u, input logic x);
    logic [7:0] r;
    logic e;
    apb(1'h0, FL_I[u], 8'h00, r, e);
    chk(16'(u == 0 ? r[ccp_pkg::FLAG1_UNIT1_BIT] : r[ccp_pkg::FLAG2_UNIT2_BIT]), 16'(x));
  endtask

  task automatic val_chk(input int u, input logic [15:0] x);
    logic [7:0] lo, hi;
    logic e;
    apb(1'h0, VL_I[u], 8'h00, lo, e);
    apb(1'h0, VH_I[u], 8'h00, hi, e);
    chk({hi, lo}, x);
  endtask

  // Level held 6 cycles; timer steps once per level phase, so captures differ
  task automatic pulse(input int u);
    lvl[u] <= 1'h1;
    repeat (6) @(posedge pclk);
    t1 <= t1 + 16'h0001;
    lvl[u] <= 1'h0;
    repeat (6) @(posedge pclk);
    t1 <= t1 + 16'h0001;
  endtask

  task automatic cap_run(input int u, input logic [3:0] m);
    int n;
    logic [15:0] v;
    n = (m == 4'h6) ? 4 : ((m == 4'h7) ? 16 : 1);
    wr(CTL_I[u], {4'h0, m});
    pulse(u);
    pulse(u);
    // Off first, else a stale prescale count fires early
    wr(CTL_I[u], 8'h00);
    wr(CTL_I[u], {4'h0, m});
    wr(FL_I[u], 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      t1 <= v;
      for (int i = 1; i < n; i++) pulse(u);
      flag_chk(u, 1'(k));
      pulse(u);
      flag_chk(u, 1'h1);
    end
    val_chk(u, cap_exp(m, v, n));
  endtask

  task automatic cmp_run(input int u, input int k);
    logic [3:0] m;
    logic [15:0] v;
    logic [7:0] r;
    logic e;
    int tr0, ad0;
    m = CMP_M[k];
    v = rnd();
    t1 <= v - 16'h0004;
    t1_wr <= (k == 2);
    adc_en <= (k != 2);
    wr(VL_I[u], v[7:0]);
    wr(VH_I[u], v[15:8]);
    wr(CTL_I[u], {4'h0, m});
    wr(FL_I[0], 8'h00);
    wr(FL_I[1], 8'h00);
    tr0 = trig_n;
    ad0 = adc_n;
    repeat (4) begin
      @(posedge pclk);
      t1 <= t1 + 16'h0001;
    end
    repeat (6) @(posedge pclk);
    if (m == 4'h8) pexp[u] = 1'h1;
    else if (m == 4'h9) pexp[u] = 1'h0;
    flag_chk(u, 1'h1);
    chk(16'(pout[u]), 16'(pexp[u]));
    chk(16'(trig_n - tr0), 16'(k == 1));
    chk(16'(adc_n - ad0), 16'(k == 1 && u == 1));
    apb(1'h0, FL_I[0], 8'h00, r, e);
    chk(16'(r[ccp_pkg::FLAG1_TIMER1_COUNT_OVF_BIT]), 16'(k == 1 && u == 0));
    wr(FL_I[u], 8'h00);
    repeat (6) @(posedge pclk);
    flag_chk(u, 1'h0);
  endtask

  initial begin
    logic [7:0] r;
    logic [7:0] d;
    logic e;
    seed = 32'h0001521A;
    presetn = 1'h0;
    {psel, penable, pwrite, t1_wr, adc_en} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    t1 = 16'h0000;
    dir = 2'h3;
    lvl = 2'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (RST_I[i]) begin
      apb(1'h0, RST_I[i], 8'h00, r, e);
      chk(16'(r), 16'h0000);
    end
    apb(1'h0, 8'h40, 8'h00, r, e);
    chk(16'({e, r}), 16'h0100);
    wr(CTL_I[0], 8'hFF);
    apb(1'h0, CTL_I[0], 8'h00, r, e);
    chk(16'(r), 16'h003F);
    wr(CTL_I[1], 8'h2C);
    apb(1'h0, CTL_I[1], 8'h00, r, e);
    chk(16'(r), 16'h002C);
    foreach (RW_I[i]) begin
      d = 8'(rnd());
      wr(RW_I[i], d);
      apb(1'h0, RW_I[i], 8'h00, r, e);
      chk(16'(r), 16'(d));
    end
    for (int u = 0; u < 2; u++) begin
      for (int m = 4; m < 8; m++) cap_run(u, 4'(m));
    end
    dir <= 2'h0;
    for (int u = 0; u < 2; u++) begin
      wr(CTL_I[u], 8'h00);
      pexp[u] = 1'h0;
      for (int k = 0; k < 5; k++) cmp_run(u, k);
      wr(CTL_I[u], 8'h00);
      repeat (2) @(posedge pclk);
      chk(16'(pout[u]), 16'h0000);
      chk(16'(pin[u]), 16'h0000);
      chk(16'(poe_n[u]), 16'h0000);
    end
    give_verdict();
  end
endmodule
